// [hdl/rgt_pkg.sv]
package rgt_pkg;

  // Counter geometry and reload value
  localparam int          RGT_CNT_W     = 16;
  localparam logic [15:0] RGT_CNT_LOAD  = 16'hffff;
  localparam logic [15:0] RGT_CNT_ZERO  = 16'h0000;

  // Reset pin pulse length in clock_in cycles
  localparam int          RGT_RST_PULSE = 4;

  // Flag reset values
  localparam logic        RGT_GEF_RST   = 1'b1;
  localparam logic        RGT_UF_RST    = 1'b0;

  // One-cycle instruction strobes from the CPU core
  typedef struct packed {
    logic restart;
    logic disable_guard;
    logic other;
  } rgt_instr_s;

  // Power mode events
  typedef struct packed {
    logic backup_entry;
    logic powerdown_entry;
  } rgt_power_s;

  typedef enum logic [1:0] {
    RGT_IDLE,
    RGT_ARMED
  } rgt_seq_e;

endpackage

// [hdl/rgt_disable_seq.sv]
`timescale 1ns/100ps
module rgt_disable_seq
  import rgt_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       instr_valid_in,
  input  wire rgt_instr_s instr_in,
  output logic            clear_enable_out
);

  rgt_seq_e state;
  rgt_seq_e next_state;

  // Only an immediately following restart completes the sequence
  assign clear_enable_out = instr_valid_in && instr_in.restart && (state == RGT_ARMED);

  always_comb begin
    next_state = state;
    if (instr_valid_in) begin
      case (state)
        RGT_IDLE:  next_state = instr_in.disable_guard ? RGT_ARMED : RGT_IDLE;
        RGT_ARMED: next_state = instr_in.disable_guard ? RGT_ARMED : RGT_IDLE;
        default:   next_state = RGT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state <= RGT_IDLE;
    end else begin
      state <= next_state;
    end
  end

endmodule // rgt_disable_seq

// [hdl/rgt_runaway_guard_timer.sv]
`timescale 1ns/100ps
// Overview of operation
// [RULE1] After reset, counter loads all ones and decrements each instruction clock.
// [RULE2] Count pulse at zero underflows and sets the first underflow flag.
// [RULE3] Underflow with first flag set sets second flag and pulls reset low.
// [RULE4] Watchdog reset acts whenever guard enable flag is one.
// [RULE5] Disable then immediately restart clears the guard enable flag.
// [RULE6] Disable alone leaves the watchdog enabled and running.
// [RULE7] Reset and RAM back-up entry force guard enable to one.
// [RULE8] Restart with first flag set clears it and skips next instruction.
// [RULE9] Restart with first flag clear does not skip.
// [RULE10] Skip still works when the watchdog reset is disabled.
// [RULE11] Power-down entry reinitializes first flag and counter.
// [RULE12] After power-down return, the watchdog reset is active again.
// [RULE13] Software restarts within 65534 machine cycles.
// [RULE14] Software restarts just before entering power-down.
// [RULE15] Software without watchdog issues disable-restart after each power-down.
// [RULE16] After underflow the counter wraps to all ones and keeps counting.
module rgt_runaway_guard_timer
  import rgt_pkg::*;
#(
  parameter int CNT_W     = RGT_CNT_W,
  parameter int RST_PULSE = RGT_RST_PULSE
)
(
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       inst_tick_in,
  input  wire logic       instr_valid_in,
  input  wire rgt_instr_s instr_in,
  input  wire rgt_power_s power_in,
  output logic            skip_next_out,
  output logic            reset_pin_out,
  output logic            reset_pin_oe_out,
  output logic            guard_enable_flag_out,
  output logic            first_underflow_flag_out,
  output logic            second_underflow_flag_out,
  output logic [CNT_W-1:0] runaway_counter_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Load is cut from the 16-bit constant, so widths above 16 are not supported
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RGT_CNT_LOAD);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(RGT_CNT_ZERO);
  localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);
  logic [CNT_W-1:0]     runaway_counter;
  logic                 guard_enable_flag;
  logic                 first_underflow_flag;
  logic                 second_underflow_flag;
  logic [7:0]           pulse_cnt;
  logic                 clear_enable;
  logic                 restart_hit;
  logic                 underflow;
  logic                 fire;

  rgt_disable_seq u_seq (
    .clock_in         (clock_in),
    .resetn_in        (resetn_in),
    .instr_valid_in   (instr_valid_in),
    .instr_in         (instr_in),
    .clear_enable_out (clear_enable)
  );

  assign restart_hit = instr_valid_in && instr_in.restart;
  assign underflow   = inst_tick_in && (runaway_counter == CNT_ZERO); // RULE2
  // Second underflow only counts while the reset function is enabled
  assign fire        = underflow && first_underflow_flag && guard_enable_flag; // RULE3 RULE4

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (!resetn_in || power_in.powerdown_entry) begin
      runaway_counter <= CNT_LOAD; // RULE1 RULE11
    end else if (inst_tick_in) begin
      runaway_counter <= runaway_counter - CNT_STEP; // RULE1 RULE16
    end
  end

  // Underflow set beats a same-cycle restart clear so no event is lost
  always_ff @(posedge clock_in) begin
    if (!resetn_in || power_in.powerdown_entry) begin
      first_underflow_flag <= RGT_UF_RST; // RULE11
    end else if (underflow) begin
      first_underflow_flag <= 1'b1; // RULE2
    end else if (restart_hit) begin
      first_underflow_flag <= 1'b0; // RULE8
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      guard_enable_flag <= RGT_GEF_RST; // RULE7
    end else if (power_in.backup_entry || power_in.powerdown_entry) begin
      guard_enable_flag <= 1'b1; // RULE7 RULE12
    end else if (clear_enable) begin
      guard_enable_flag <= 1'b0; // RULE5 RULE6
    end
  end

  // Pulse outlives the system reset it causes; counts down itself
  always_ff @(posedge clock_in) begin
    if (!resetn_in && pulse_cnt == 8'h00) begin
      second_underflow_flag <= 1'b0;
    end else if (fire) begin
      second_underflow_flag <= 1'b1; // RULE3
    end
  end

  // Any count that is not running falls to idle, so the pin starts released
  always_ff @(posedge clock_in) begin
    if (fire) begin
      pulse_cnt <= RST_PULSE[7:0]; // RULE3
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end else begin
      pulse_cnt <= 8'h00;
    end
  end

  // Skip decision is independent of the enable flag
  assign skip_next_out             = restart_hit && first_underflow_flag; // RULE8 RULE9 RULE10
  assign reset_pin_out             = 1'b0;
  assign reset_pin_oe_out          = (pulse_cnt != 8'h00); // RULE3
  assign guard_enable_flag_out     = guard_enable_flag;
  assign first_underflow_flag_out  = first_underflow_flag;
  assign second_underflow_flag_out = second_underflow_flag;
  assign runaway_counter_out       = runaway_counter;

  ////////////////////////////////////////////////////////////////////////////
  property p_load;
    @(posedge clock_in) $rose(resetn_in) |-> runaway_counter == CNT_LOAD;
  endproperty
  a_load: assert property (p_load) else $error("counter not all ones after reset"); // RULE1

  property p_dec;
    @(posedge clock_in) disable iff (!resetn_in)
      inst_tick_in && !power_in.powerdown_entry && runaway_counter != CNT_ZERO
      |=> runaway_counter == $past(runaway_counter) - CNT_STEP;
  endproperty
  a_dec: assert property (p_dec) else $error("counter did not decrement"); // RULE1

  property p_uf;
    @(posedge clock_in) disable iff (!resetn_in)
      underflow && !power_in.powerdown_entry |=> first_underflow_flag;
  endproperty
  a_uf: assert property (p_uf) else $error("first flag not set"); // RULE2

  property p_wrap;
    @(posedge clock_in) disable iff (!resetn_in)
      underflow |=> runaway_counter == CNT_LOAD;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap after underflow"); // RULE16

  property p_fire;
    @(posedge clock_in) disable iff (!resetn_in)
      underflow && first_underflow_flag && guard_enable_flag
      |=> reset_pin_oe_out && second_underflow_flag && !reset_pin_out;
  endproperty
  a_fire: assert property (p_fire) else $error("watchdog reset missing"); // RULE3

  property p_nofire;
    @(posedge clock_in) disable iff (!resetn_in)
      !guard_enable_flag && pulse_cnt == 8'h00 |=> !reset_pin_oe_out;
  endproperty
  a_nofire: assert property (p_nofire) else $error("reset while disabled"); // RULE4

  property p_dis;
    @(posedge clock_in) disable iff (!resetn_in)
      instr_valid_in && instr_in.disable_guard ##1 instr_valid_in && instr_in.restart
      && !power_in.backup_entry && !power_in.powerdown_entry |=> !guard_enable_flag;
  endproperty
  a_dis: assert property (p_dis) else $error("disable sequence ignored"); // RULE5

  property p_alone;
    @(posedge clock_in) disable iff (!resetn_in)
      guard_enable_flag && !(instr_valid_in && instr_in.restart) |=> guard_enable_flag;
  endproperty
  a_alone: assert property (p_alone) else $error("enable lost without restart"); // RULE6

  property p_pwr;
    @(posedge clock_in) disable iff (!resetn_in)
      power_in.backup_entry || power_in.powerdown_entry |=> guard_enable_flag;
  endproperty
  a_pwr: assert property (p_pwr) else $error("enable not forced"); // RULE7

  property p_skip;
    @(posedge clock_in) disable iff (!resetn_in)
      restart_hit |-> skip_next_out == first_underflow_flag;
  endproperty
  a_skip: assert property (p_skip) else $error("wrong skip decision"); // RULE8

  property p_pd;
    @(posedge clock_in) disable iff (!resetn_in)
      power_in.powerdown_entry |=> !first_underflow_flag && runaway_counter == CNT_LOAD;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down init missing"); // RULE11

  property p_noskip;
    @(posedge clock_in) disable iff (!resetn_in)
      restart_hit && !first_underflow_flag |-> !skip_next_out;
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip without first flag"); // RULE9

  property p_skip_off;
    @(posedge clock_in) disable iff (!resetn_in)
      restart_hit && first_underflow_flag && !guard_enable_flag |-> skip_next_out;
  endproperty
  a_skip_off: assert property (p_skip_off) else $error("skip lost while disabled"); // RULE10

  property p_oe_src;
    @(posedge clock_in) disable iff (!resetn_in)
      $rose(reset_pin_oe_out) |-> $past(fire);
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("reset pin pulled without fire"); // RULE3

  property p_stay_off;
    @(posedge clock_in) disable iff (!resetn_in)
      !guard_enable_flag && !power_in.backup_entry && !power_in.powerdown_entry
      |=> !guard_enable_flag;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("enable raised on its own"); // RULE7

  c_fire:   cover property (@(posedge clock_in) fire);
  c_skip:   cover property (@(posedge clock_in) skip_next_out && !guard_enable_flag);
  c_dis:    cover property (@(posedge clock_in) clear_enable);
  c_refuse: cover property (@(posedge clock_in)
    underflow && first_underflow_flag && !guard_enable_flag);
  c_pd:     cover property (@(posedge clock_in) power_in.powerdown_entry);

endmodule // rgt_runaway_guard_timer

// [bench/rgt_cpu_model.sv]
`timescale 1ns/100ps
module rgt_cpu_model
  import rgt_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic pin_in,
  input  wire logic pin_oe_in,
  output logic       instr_valid_out,
  output rgt_instr_s instr_out,
  output logic       reset_line_out
);
  // Pulled up when released, so an idle pin never reads as a reset
  assign reset_line_out = pin_oe_in ? pin_in : 1'b1;
  initial begin
    instr_valid_out = 1'b0;
    instr_out = '0;
  end
  // One instruction per call, held valid until the next issue or idle call
  task automatic issue(input rgt_instr_s op);
    @(negedge clock_in);
    instr_valid_out = 1'b1;
    instr_out = op;
  endtask
  // Junk opcode while not valid, as a real core would show
  task automatic idle();
    @(negedge clock_in);
    instr_valid_out = 1'b0;
    instr_out = rgt_instr_s'(3'($urandom));
  endtask
endmodule // rgt_cpu_model

// [bench/rgt_runaway_guard_timer_bench.sv]
`timescale 1ns/100ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module rgt_runaway_guard_timer_bench import rgt_pkg::*;;
  localparam rgt_instr_s RS = 3'b100;
  localparam rgt_instr_s DS = 3'b010;
  localparam rgt_instr_s OT = 3'b001;
  // Narrow counter keeps the four full periods of the run short
  localparam int            CW   = 8;
  localparam logic [CW-1:0] LOAD = CW'(RGT_CNT_LOAD);
  localparam logic [CW-1:0] ZERO = CW'(RGT_CNT_ZERO);
  logic       clock_in, resetn_in, tick, valid, pin, pin_oe;
  logic       gef, uf1, uf2, skip, rline;
  rgt_instr_s instr;
  rgt_power_s power;
  logic [CW-1:0] cnt, exp_cnt;
  int         n_fail, cmp_count, k;

  rgt_runaway_guard_timer #(.CNT_W(CW)) dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .inst_tick_in(tick), .instr_valid_in(valid), .instr_in(instr), .power_in(power),
    .skip_next_out(skip), .reset_pin_out(pin), .reset_pin_oe_out(pin_oe),
    .guard_enable_flag_out(gef), .first_underflow_flag_out(uf1),
    .second_underflow_flag_out(uf2), .runaway_counter_out(cnt));
  rgt_cpu_model cpu_u (.clock_in(clock_in), .pin_in(pin), .pin_oe_in(pin_oe),
    .instr_valid_out(valid), .instr_out(instr), .reset_line_out(rline));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic ticks(input int n, input bit rnd);
    for (int i = 0; i < n; i++) begin
      @(negedge clock_in);
      tick = rnd ? 1'($urandom) : 1'b1;
      if (tick) exp_cnt--;
    end
    @(negedge clock_in);
    tick = 1'b0;
  endtask
  task automatic op(input rgt_instr_s o, input logic s);
    cpu_u.issue(o);
    #1 `CHK(skip, s)
    cpu_u.idle();
  endtask
  // Mode entry strobes last exactly one cycle
  task automatic pwr(input rgt_power_s p);
    @(negedge clock_in);
    power = p;
    @(negedge clock_in);
    power = '0;
  endtask
  // Ticks from a fresh load up to and including the underflow
  function automatic int period();
    return 1 << CW;
  endfunction
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    tick = 1'b0;
    power = '0;
    exp_cnt = 16'hffff;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'he97e));
    repeat (20) @(negedge clock_in);
    resetn_in = 1'b1;
    `CHK(cnt, LOAD)
    `CHK(gef, 1'b1)
    `CHK(pin_oe, 1'b0)
    // Both random runs together stay short of an underflow
    ticks($urandom_range(150, 50), 1'b1);
    `CHK(cnt, exp_cnt)
    op(RS, 1'b0);
    op(DS, 1'b0);
    op(OT, 1'b0);
    op(RS, 1'b0);
    `CHK(gef, 1'b1)
    op(DS, 1'b0);
    op(RS, 1'b0);
    `CHK(gef, 1'b0)
    pwr(2'b10);
    `CHK(gef, 1'b1)
    op(DS, 1'b0);
    op(RS, 1'b0);
    ticks($urandom_range(90, 9), 1'b1);
    `CHK(cnt, exp_cnt)
    op(RS, 1'b0);
    pwr(2'b01);
    exp_cnt = LOAD;
    `CHK(cnt, exp_cnt)
    `CHK(gef, 1'b1)
    ticks(period() - 1, 1'b0);
    `CHK(cnt, ZERO)
    `CHK(uf1, 1'b0)
    ticks(1, 1'b0);
    `CHK(uf1, 1'b1)
    `CHK(cnt, LOAD)
    // Second period without a restart: the guard must fire
    ticks(period(), 1'b0);
    for (k = 0; k < 4 && pin_oe !== 1'b1; k++) @(negedge clock_in);
    `CHK(pin_oe, 1'b1)
    `CHK(rline, 1'b0)
    `CHK(uf2, 1'b1)
    k = 0;
    while (pin_oe === 1'b1 && k < 20) begin
      @(negedge clock_in);
      k++;
    end
    `CHK(k, RGT_RST_PULSE)
    op(RS, 1'b1);
    `CHK(uf1, 1'b0)
    // Back-to-back disable and restart; flag is clear, so no skip
    cpu_u.issue(DS);
    cpu_u.issue(RS);
    #1 `CHK(skip, 1'b0)
    cpu_u.idle();
    `CHK(gef, 1'b0)
    // Two underflows while disabled: the second must be refused
    ticks(period(), 1'b0);
    `CHK(uf1, 1'b1)
    ticks(period(), 1'b0);
    `CHK(pin_oe, 1'b0)
    `CHK(rline, 1'b1)
    op(DS, 1'b0);
    op(RS, 1'b1);
    `CHK(uf1, 1'b0)
    `CHK(gef, 1'b0)
    resetn_in = 1'b0;
    repeat (20) @(negedge clock_in);
    resetn_in = 1'b1;
    `CHK(gef, 1'b1)
    `CHK(cnt, LOAD)
    `CHK(uf2, 1'b0)
    results();
  end

  // Cuts a hang short
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule // rgt_runaway_guard_timer_bench
